// file: design/byte_pair_reader.sv
// Coherent two-byte reader: reading one half freezes the other half
`timescale 1ns/1ps
`include "timer_defs.svh"

module byte_pair_reader (
   // Clock and reset
   input  wire logic   core_clk,
   input  wire logic   sys_rst,
   // Core side
   byte_read_if.rdr    rd
);

   timer_pkg::reader_t st;
   timer_pkg::reader_t next_st;

   // =============================================================
   // Read sequencing
   always_comb begin
      next_st = st;
      if (rd.restart) begin
         // Drop any pending partner byte
         next_st.hold_low  = 1'b0;
         next_st.hold_high = 1'b0;
      end else if (rd.rd_high) begin
         if (st.hold_high) begin
            next_st.data      = st.buffer;
            next_st.hold_high = 1'b0;
         end else begin
            next_st.data     = rd.word[`TMR_HI];
            next_st.buffer   = rd.word[`TMR_LO];  // Freeze low half
            next_st.hold_low = 1'b1;
         end
      end else if (rd.rd_low) begin
         if (st.hold_low) begin
            next_st.data     = st.buffer;
            next_st.hold_low = 1'b0;
         end else begin
            next_st.data      = rd.word[`TMR_LO];
            next_st.buffer    = rd.word[`TMR_HI]; // Freeze high half
            next_st.hold_high = 1'b1;
         end
      end
   end

   // =============================================================
   // State register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rd.data = st.data;

endmodule

// file: design/byte_read_if.sv
// Carrier between the core and one coherent byte pair reader
`timescale 1ns/1ps
`include "timer_defs.svh"

interface byte_read_if;
   logic [`TMR_CNT_W-1:0]  word;
   logic                   rd_high;
   logic                   rd_low;
   logic                   restart;
   logic [`TMR_BYTE_W-1:0] data;

   modport src (output word, output rd_high, output rd_low, output restart, input data);
   modport rdr (input word, input rd_high, input rd_low, input restart, output data);
endinterface

// file: design/timer_capture_compare_core.sv
// Sixteen-bit timer counter with input capture and output compare channels
//
// Functional notes
// RL1: Center-aligned select high gives up/down counting, else plain up counting.
// RL2: Up counting runs from zero to terminal count, then wraps to zero.
// RL3: Terminal count is all ones with zero modulus, else the modulus.
// RL4: Center-aligned counts up to terminal, down to zero, then up again.
// RL5: Zero and terminal count each last one clock, like any count.
// RL6: Center-aligned overflow sets as count leaves terminal count downward.
// RL7: Writing either counter byte resets the counter at any time.
// RL8: Counter reset also drops any pending buffered counter byte.
// RL9: With center-aligned off, two mode bits select capture, compare or PWM.
// RL10: Active capture edge copies the counter into the channel value.
// RL11: Capture edge selectable as rising, falling or either.
// RL12: In capture mode, software writes to value bytes are ignored.
// RL13: Reading one value byte freezes the other for coherent reads.
// RL14: Writing channel status and control restarts value read coherency.
// RL15: Capture sets channel flag; flag raises request when enabled.
// RL16: Capture keeps working in debug halt, latching the frozen count.
// RL17: Compare match sets, clears or toggles the channel pin.
// RL18: Up counting sets overflow when wrapping from terminal count to zero.
// RL19: Compare match sets channel flag and raises request when enabled.
`timescale 1ns/1ps
`include "timer_defs.svh"

module timer_capture_compare_core (
   // Clock and reset
   input  wire logic                                     core_clk,
   input  wire logic                                     sys_rst,

   // Global mode
   input  wire logic                                     center_aligned_select,
   input  wire logic                                     debug_halt_mode,

   // Shared software write data
   input  wire logic [`TMR_BYTE_W-1:0]                   wr_data,

   // Modulus byte writes
   input  wire logic                                     modulus_high_wr,
   input  wire logic                                     modulus_low_wr,

   // Counter byte access
   input  wire logic                                     counter_high_wr,
   input  wire logic                                     counter_low_wr,
   input  wire logic                                     counter_high_rd,
   input  wire logic                                     counter_low_rd,
   output logic      [`TMR_BYTE_W-1:0]                   counter_rd_data,

   // Overflow
   input  wire logic                                     overflow_clear,
   output logic                                          counter_overflow_flag,

   // Channel software access
   input  wire logic [`TMR_NUM_CH-1:0]                   channel_status_control_wr,
   input  wire logic [`TMR_NUM_CH-1:0]                   channel_value_high_wr,
   input  wire logic [`TMR_NUM_CH-1:0]                   channel_value_low_wr,
   input  wire logic [`TMR_NUM_CH-1:0]                   channel_value_high_rd,
   input  wire logic [`TMR_NUM_CH-1:0]                   channel_value_low_rd,
   input  wire logic [`TMR_NUM_CH-1:0]                   channel_flag_clear,
   output logic      [`TMR_NUM_CH-1:0][`TMR_BYTE_W-1:0]  channel_value_rd_data,
   output logic      [`TMR_NUM_CH-1:0][`TMR_SC_W-1:0]    channel_status_control,

   // Channel events
   output logic      [`TMR_NUM_CH-1:0]                   channel_event_flag,
   output logic      [`TMR_NUM_CH-1:0]                   channel_irq,

   // Channel pins
   input  wire logic [`TMR_NUM_CH-1:0]                   channel_pin_in,
   output logic      [`TMR_NUM_CH-1:0]                   channel_pin_out,
   output logic      [`TMR_NUM_CH-1:0]                   channel_pin_oe_n
);

   timer_pkg::core_t st;
   timer_pkg::core_t next_st;

   // =============================================================
   // Terminal count
   logic [`TMR_CNT_W-1:0] top;
   logic                  counter_wr;

   // A zero modulus means free running over the full range
   assign top        = (st.modulus == `TMR_ZERO) ? `TMR_TOP_FULL : st.modulus; // [RL3]
   assign counter_wr = counter_high_wr | counter_low_wr;

   // =============================================================
   // Counter byte reader
   byte_read_if cnt_rd ();

   // The coherency buffer is dropped on a manual reset of the count
   assign cnt_rd.word    = st.count;
   assign cnt_rd.rd_high = counter_high_rd;
   assign cnt_rd.rd_low  = counter_low_rd;
   assign cnt_rd.restart = counter_wr;  // [RL8]

   byte_pair_reader cnt_reader (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .rd       (cnt_rd.rdr)
   );

   assign counter_rd_data = cnt_rd.data;

   // =============================================================
   // Channel value byte readers
   genvar g;
   generate
      for (g = 0; g < `TMR_NUM_CH; g++) begin : gen_ch_rd
         byte_read_if ch_rd ();

         // Reads are served in every mode; capture mode is where coherency matters
         assign ch_rd.word    = st.ch[g].value;
         assign ch_rd.rd_high = channel_value_high_rd[g];
         assign ch_rd.rd_low  = channel_value_low_rd[g];
         assign ch_rd.restart = channel_status_control_wr[g]; // [RL14]

         byte_pair_reader ch_reader (
            .core_clk (core_clk),
            .sys_rst  (sys_rst),
            .rd       (ch_rd.rdr)  // [RL13]
         );

         assign channel_value_rd_data[g] = ch_rd.data;
      end
   endgenerate

   // =============================================================
   // Next state: counter first, as the channels compare against the next count
   logic                   ovf_set;
   logic                   counter_step;
   logic [`TMR_NUM_CH-1:0] cap_hit;
   logic [`TMR_NUM_CH-1:0] cmp_hit;

   always_comb begin
      logic       rise;
      logic       fall;
      logic [1:0] mode;
      logic [1:0] sel;
      rise    = 1'b0;
      fall    = 1'b0;
      mode    = `TMR_MODE_CAPTURE;
      sel     = `TMR_EDGE_NONE;
      next_st.count   = st.count;
      next_st.dir     = st.dir;
      next_st.modulus = st.modulus;
      ovf_set         = 1'b0;
      counter_step    = 1'b0;

      // Modulus bytes are taken directly
      if (modulus_high_wr) begin
         next_st.modulus[`TMR_HI] = wr_data;
      end
      if (modulus_low_wr) begin
         next_st.modulus[`TMR_LO] = wr_data;
      end

      if (counter_wr) begin
         // Manual reset wins even during debug halt
         next_st.count = `TMR_ZERO;  // [RL7]
         next_st.dir   = timer_pkg::dir_up;
         counter_step  = 1'b1;
      end else if (!debug_halt_mode) begin
         counter_step = 1'b1;
         if (center_aligned_select) begin  // [RL1]
            unique case (st.dir)
               timer_pkg::dir_up: begin
                  if (st.count >= top) begin
                     // Terminal count held one clock, then step down
                     next_st.count = st.count - `TMR_ONE;  // [RL4] [RL5]
                     next_st.dir   = timer_pkg::dir_down;
                     ovf_set       = 1'b1;  // [RL6]
                  end else begin
                     next_st.count = st.count + `TMR_ONE;
                  end
               end
               timer_pkg::dir_down: begin
                  if (st.count == `TMR_ZERO) begin
                     // Zero held one clock, then back to counting up
                     next_st.count = `TMR_ONE;  // [RL4] [RL5]
                     next_st.dir   = timer_pkg::dir_up;
                  end else begin
                     next_st.count = st.count - `TMR_ONE;
                  end
               end
            endcase
         end else begin
            // A modulus lowered below the count also wraps at once
            next_st.dir = timer_pkg::dir_up;
            if (st.count >= top) begin
               next_st.count = `TMR_ZERO;  // [RL2]
               ovf_set       = 1'b1;  // [RL18]
            end else begin
               next_st.count = st.count + `TMR_ONE;  // [RL2]
            end
         end
      end

      // Set wins over a clear in the same cycle
      next_st.ovf = (st.ovf & ~overflow_clear) | ovf_set;

      // Channels
      cap_hit = '0;
      cmp_hit = '0;
      next_st.ch = st.ch;

      for (int i = 0; i < `TMR_NUM_CH; i++) begin
         if (channel_status_control_wr[i]) begin
            next_st.ch[i].sc = wr_data[`TMR_SC_W-1:0];
         end
         mode = st.ch[i].sc[`TMR_SC_MODE];
         sel  = st.ch[i].sc[`TMR_SC_SEL];
         next_st.ch[i].pin_prev = channel_pin_in[i];
         rise = channel_pin_in[i] & ~st.ch[i].pin_prev;
         fall = ~channel_pin_in[i] & st.ch[i].pin_prev;

         if (center_aligned_select) begin
            // Center-aligned PWM: high while below the channel value
            next_st.ch[i].pin_oe_n = 1'b0;
            next_st.ch[i].pin_out  = (next_st.count < st.ch[i].value);
         end else if (mode == `TMR_MODE_CAPTURE) begin  // [RL9]
            // Pin is an input here, so release it
            next_st.ch[i].pin_oe_n = 1'b1;
            unique case (sel)  // [RL11]
               `TMR_EDGE_RISE: cap_hit[i] = rise;
               `TMR_EDGE_FALL: cap_hit[i] = fall;
               `TMR_EDGE_BOTH: cap_hit[i] = rise | fall;
               `TMR_EDGE_NONE: cap_hit[i] = 1'b0;
            endcase
            // Halt only freezes the count, so capture still latches it
            if (cap_hit[i]) begin
               next_st.ch[i].value = st.count;  // [RL10] [RL16]
            end
         end else if (mode == `TMR_MODE_COMPARE) begin
            next_st.ch[i].pin_oe_n = 1'b0;
            // Match only when the count steps or is reset onto the value, not while halted without a counter write
            cmp_hit[i] = counter_step && (next_st.count == st.ch[i].value);
            if (cmp_hit[i]) begin
               unique case (sel)  // [RL17]
                  `TMR_ACT_TOGGLE: next_st.ch[i].pin_out = ~st.ch[i].pin_out;
                  `TMR_ACT_CLEAR:  next_st.ch[i].pin_out = 1'b0;
                  `TMR_ACT_SET:    next_st.ch[i].pin_out = 1'b1;
                  `TMR_ACT_NONE:   next_st.ch[i].pin_out = st.ch[i].pin_out;
               endcase
            end
         end else begin
            // Edge-aligned PWM: high from zero until the value is reached
            next_st.ch[i].pin_oe_n = 1'b0;
            next_st.ch[i].pin_out  = (next_st.count < st.ch[i].value);
         end

         // Value bytes are written only outside capture mode
         if (center_aligned_select || mode != `TMR_MODE_CAPTURE) begin  // [RL12]
            if (channel_value_high_wr[i]) begin
               next_st.ch[i].value[`TMR_HI] = wr_data;
            end
            if (channel_value_low_wr[i]) begin
               next_st.ch[i].value[`TMR_LO] = wr_data;
            end
         end

         // Event wins over a clear arriving in the same cycle
         next_st.ch[i].flag = (st.ch[i].flag & ~channel_flag_clear[i])
                              | cap_hit[i]    // [RL15]
                              | cmp_hit[i];   // [RL19]
         next_st.ch[i].irq  = next_st.ch[i].flag & next_st.ch[i].sc[`TMR_SC_IE]; // [RL15] [RL19]
      end
   end

   // =============================================================
   // State register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
         // Channels wake up in capture mode with pins released
         for (int i = 0; i < `TMR_NUM_CH; i++) begin
            st.ch[i].pin_oe_n <= 1'b1;
         end
      end else begin
         st <= next_st;
      end
   end

   // =============================================================
   // Outputs, all taken from the state register
   assign counter_overflow_flag = st.ovf;

   always_comb begin
      for (int i = 0; i < `TMR_NUM_CH; i++) begin
         channel_status_control[i] = st.ch[i].sc;
         channel_event_flag[i]     = st.ch[i].flag;
         channel_irq[i]            = st.ch[i].irq;
         channel_pin_out[i]        = st.ch[i].pin_out;
         channel_pin_oe_n[i]       = st.ch[i].pin_oe_n;
      end
   end

endmodule

// file: design/timer_defs.svh
// Constants for the timer counter with capture and compare channels
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// =============================================================
// Widths and counts
`define TMR_CNT_W      16
`define TMR_BYTE_W     8
`define TMR_NUM_CH     2
`define TMR_HI         15:8
`define TMR_LO         7:0
`define TMR_ZERO       16'h0000
`define TMR_ONE        16'h0001
`define TMR_TOP_FULL   16'hffff

// =============================================================
// Channel status and control fields
`define TMR_SC_W       5
`define TMR_SC_IE      4
`define TMR_SC_MODE    3:2
`define TMR_SC_SEL     1:0

// Mode field {mode_b, mode_a}
`define TMR_MODE_CAPTURE 2'h0
`define TMR_MODE_COMPARE 2'h1

// Capture edge select
`define TMR_EDGE_NONE  2'h0
`define TMR_EDGE_RISE  2'h1
`define TMR_EDGE_FALL  2'h2
`define TMR_EDGE_BOTH  2'h3

// Compare pin action
`define TMR_ACT_NONE   2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR  2'h2
`define TMR_ACT_SET    2'h3

`endif

// file: design/timer_pkg.sv
// Types shared by the timer core and its byte pair readers
`include "timer_defs.svh"

package timer_pkg;

   // Count direction
   typedef enum logic {dir_up, dir_down} dir_t;

   // One channel
   typedef struct packed {
      logic [`TMR_SC_W-1:0]  sc;
      logic [`TMR_CNT_W-1:0] value;
      logic                  pin_prev;
      logic                  pin_out;
      logic                  pin_oe_n;
      logic                  flag;
      logic                  irq;
   } chan_t;

   // Whole core state
   typedef struct packed {
      logic [`TMR_CNT_W-1:0]            count;
      logic [`TMR_CNT_W-1:0]            modulus;
      dir_t                             dir;
      logic                             ovf;
      chan_t [`TMR_NUM_CH-1:0]          ch;
   } core_t;

   // Coherent byte reader state
   typedef struct packed {
      logic [`TMR_BYTE_W-1:0] buffer;
      logic                   hold_low;
      logic                   hold_high;
      logic [`TMR_BYTE_W-1:0] data;
   } reader_t;

endpackage

// file: testbench/event_pin_model.sv
// External event source and load on the channel pins
`timescale 1ns/1ps
`include "timer_defs.svh"

module event_pin_model (
   // Clock
   input  wire logic                   core_clk,
   // Pin side of the core
   input  wire logic [`TMR_NUM_CH-1:0] pin_out,
   input  wire logic [`TMR_NUM_CH-1:0] pin_oe_n,
   output logic      [`TMR_NUM_CH-1:0] pin_in
);
   logic [`TMR_NUM_CH-1:0] level;

   // Wire level: the core wins while it drives, else the external source
   assign pin_in = (pin_oe_n & level) | (~pin_oe_n & pin_out);

   initial level = '0;

   // New level lands off the sampling edge and then holds
   task automatic drive(input int ch, input logic v);
      @(negedge core_clk);
      level[ch] = v;
   endtask
endmodule

// file: testbench/tb_timer_capture_compare_core.sv
// Self-checking bench for the timer capture and compare core
`timescale 1ns/1ps

module tb_timer_capture_compare_core;
   // =====================
   // Strobe bit positions and signals
   localparam int SC = 0;
   localparam int VH = 2;
   localparam int VL = 4;
   localparam int FC = 6;
   localparam int ML = 8;
   localparam int MH = 9;
   localparam int CL = 10;
   localparam int CH = 11;
   localparam int OC = 12;
   logic            core_clk;
   logic            sys_rst;
   logic            center;
   logic            halt;
   logic [7:0]      wr_data;
   logic [12:0]     ws;
   logic [2:0]      hrd;
   logic [2:0]      lrd;
   logic [7:0]      cnt_byte;
   logic            ovf;
   logic [1:0][7:0] val_byte;
   logic [1:0][4:0] sc;
   logic [1:0]      flag;
   logic [1:0]      irq;
   logic [1:0]      pin_in;
   logic [1:0]      pin_out;
   logic [1:0]      pin_oe_n;
   logic [2:0][7:0] rdd;
   logic [15:0]     got;
   int              fails = 0;
   int              check_count = 0;

   // Read bytes indexed by source, the counter at 2
   assign rdd = {cnt_byte, val_byte};

   timer_capture_compare_core timer_capture_compare_core_i (
      .core_clk(core_clk), .sys_rst(sys_rst), .center_aligned_select(center),
      .debug_halt_mode(halt), .wr_data(wr_data), .modulus_high_wr(ws[MH]),
      .modulus_low_wr(ws[ML]), .counter_high_wr(ws[CH]), .counter_low_wr(ws[CL]),
      .counter_high_rd(hrd[2]), .counter_low_rd(lrd[2]), .counter_rd_data(cnt_byte),
      .overflow_clear(ws[OC]), .counter_overflow_flag(ovf),
      .channel_status_control_wr(ws[SC+:2]), .channel_value_high_wr(ws[VH+:2]),
      .channel_value_low_wr(ws[VL+:2]), .channel_value_high_rd(hrd[1:0]),
      .channel_value_low_rd(lrd[1:0]), .channel_flag_clear(ws[FC+:2]),
      .channel_value_rd_data(val_byte), .channel_status_control(sc),
      .channel_event_flag(flag), .channel_irq(irq), .channel_pin_in(pin_in),
      .channel_pin_out(pin_out), .channel_pin_oe_n(pin_oe_n));

   event_pin_model event_pin_model_i (.core_clk(core_clk), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_in(pin_in));

   // =====================
   // Shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One-cycle strobe, dropped at the next falling edge
   task automatic wr(input int b, input logic [7:0] d);
      @(negedge core_clk);
      wr_data = d;
      ws[b] = 1'b1;
      @(negedge core_clk);
      ws = '0;
   endtask

   // High byte first, so the low byte must come from the frozen copy
   task automatic rd16(input int src, output logic [15:0] v);
      @(negedge core_clk);
      hrd[src] = 1'b1;
      @(negedge core_clk);
      hrd = '0;
      lrd[src] = 1'b1;
      v[15:8] = rdd[src];
      @(negedge core_clk);
      lrd = '0;
      v[7:0] = rdd[src];
   endtask

   // Restart, wait n cycles, read count n+1
   task automatic cnt_read(input int n, output logic [15:0] v);
      wr(CL, 8'h5a);
      repeat (n) @(negedge core_clk);
      rd16(2, v);
   endtask

   // =====================
   // Scenarios
   task automatic t_up;
      wr(MH, 8'h01);
      wr(ML, 8'h02);
      for (int j = 16'h0101; j <= 16'h0105; j += 2) begin
         cnt_read(j - 1, got);
         chk(got, 16'(j % 16'h0103));
      end
      $display("up count test done");
   endtask

   task automatic t_ovf(input logic ctr);
      int p;
      center = ctr;
      wr(MH, 8'h00);
      wr(ML, 8'h03);
      wr(CL, 8'h00);
      wr(OC, 8'h00);
      @(negedge core_clk);
      chk(ovf, 1'b0);
      @(negedge core_clk);
      chk(ovf, 1'b1);
      for (int j = 3; j <= 7; j++) begin
         cnt_read(j - 1, got);
         p = ctr ? ((j % 6) <= 3 ? j % 6 : 6 - j % 6) : j % 4;
         chk(got, 16'(p));
      end
      $display("overflow test done, center %0d", ctr);
   endtask

   // A counter write between the two byte reads must drop the frozen byte
   task automatic t_restart;
      wr(ML, 8'h00);
      wr(CL, 8'h00);
      repeat (16'h20) @(negedge core_clk);
      hrd[2] = 1'b1;
      @(negedge core_clk);
      hrd = '0;
      ws[CH] = 1'b1;
      chk(rdd[2], 8'h00);
      @(negedge core_clk);
      ws = '0;
      lrd[2] = 1'b1;
      @(negedge core_clk);
      lrd = '0;
      chk(rdd[2], 8'h00);
      rd16(2, got);
      chk(got, 16'h0003);
      $display("manual reset test done");
   endtask

   task automatic t_capture;
      wr(CL, 8'h00);
      repeat (16'h40) @(negedge core_clk);
      halt = 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(SC, 8'h10 + 8'(s));
         wr(FC, 8'h00);
         event_pin_model_i.drive(0, 1'b1);
         repeat (2) @(negedge core_clk);
         chk(flag[0], s[0]);
         chk(irq[0], s[0]);
         wr(FC, 8'h00);
         event_pin_model_i.drive(0, 1'b0);
         repeat (2) @(negedge core_clk);
         chk(flag[0], s[1]);
      end
      rd16(0, got);
      chk(got, 16'h0040);
      wr(VH, 8'hff);
      wr(VL, 8'hff);
      rd16(0, got);
      chk(got, 16'h0040);
      halt = 1'b0;
      $display("capture test done");
   endtask

   // Set, clear, toggle, no action, flag each time; then edge PWM
   task automatic t_compare;
      logic e = 1'b0;
      for (int a = 3; a >= 0; a--) begin
         wr(SC, 8'h14 + 8'(a));
         wr(VH, 8'h00);
         wr(VL, 8'h10);
         wr(FC, 8'h00);
         wr(CL, 8'h00);
         repeat (15) @(negedge core_clk);
         chk(pin_out[0], e);
         e = a == 3 ? 1'b1 : a == 2 ? 1'b0 : a == 1 ? ~e : e;
         @(negedge core_clk);
         chk(pin_out[0], e);
         chk({flag[0], irq[0], pin_oe_n[0]}, 3'b110);
      end
      halt = 1'b1;
      repeat (4) @(negedge core_clk);
      chk(pin_out[0], e);
      halt = 1'b0;
      wr(SC, 8'h08);
      wr(CL, 8'h00);
      chk(pin_out[0], 1'b1);
      repeat (16) @(negedge core_clk);
      chk(pin_out[0], 1'b0);
      $display("compare test done");
   endtask

   // =====================
   // Clock, watchdog and main sequence
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   initial begin
      #40000;
      fails++;
      report_and_stop;
   end

   initial begin
      sys_rst = 1'b1;
      center = 1'b0;
      halt = 1'b0;
      wr_data = 8'h00;
      ws = '0;
      hrd = '0;
      lrd = '0;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      t_up;
      t_ovf(1'b1);
      t_ovf(1'b0);
      t_restart;
      t_capture;
      t_compare;
      report_and_stop;
   end
endmodule

bind timer_capture_compare_core timer_port_monitor timer_port_monitor_i (
   .core_clk(core_clk), .sys_rst(sys_rst), .center_aligned_select(center_aligned_select),
   .debug_halt_mode(debug_halt_mode), .counter_high_rd(counter_high_rd),
   .counter_low_rd(counter_low_rd), .counter_rd_data(counter_rd_data),
   .overflow_clear(overflow_clear), .counter_overflow_flag(counter_overflow_flag),
   .channel_status_control_wr(channel_status_control_wr),
   .channel_flag_clear(channel_flag_clear), .channel_status_control(channel_status_control),
   .channel_event_flag(channel_event_flag), .channel_irq(channel_irq),
   .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
   .channel_pin_oe_n(channel_pin_oe_n));

// file: testbench/timer_port_monitor.sv
// Port-level assertions for the timer capture and compare core
`timescale 1ns/1ps
`include "timer_defs.svh"

module timer_port_monitor (
   // Clock and reset
   input wire logic                                  core_clk,
   input wire logic                                  sys_rst,
   // Counter side
   input wire logic                                  center_aligned_select,
   input wire logic                                  debug_halt_mode,
   input wire logic                                  counter_high_rd,
   input wire logic                                  counter_low_rd,
   input wire logic [`TMR_BYTE_W-1:0]                counter_rd_data,
   input wire logic                                  overflow_clear,
   input wire logic                                  counter_overflow_flag,
   // Channel side
   input wire logic [`TMR_NUM_CH-1:0]                channel_status_control_wr,
   input wire logic [`TMR_NUM_CH-1:0]                channel_flag_clear,
   input wire logic [`TMR_NUM_CH-1:0][`TMR_SC_W-1:0] channel_status_control,
   input wire logic [`TMR_NUM_CH-1:0]                channel_event_flag,
   input wire logic [`TMR_NUM_CH-1:0]                channel_irq,
   input wire logic [`TMR_NUM_CH-1:0]                channel_pin_in,
   input wire logic [`TMR_NUM_CH-1:0]                channel_pin_out,
   input wire logic [`TMR_NUM_CH-1:0]                channel_pin_oe_n
);
   // =====================
   // Channel 0 fields
   logic [1:0] mode0;
   logic [1:0] sel0;
   logic       cap0;
   assign mode0 = channel_status_control[0][`TMR_SC_MODE];
   assign sel0 = channel_status_control[0][`TMR_SC_SEL];
   assign cap0 = !center_aligned_select && mode0 == `TMR_MODE_CAPTURE;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // =====================
   // Counter and read port
   a_overflow_sticky: assert property (
      counter_overflow_flag && !overflow_clear |=> counter_overflow_flag)
      else $error("overflow flag fell without a clear");
   a_overflow_halted: assert property (
      $past(debug_halt_mode) |-> !$rose(counter_overflow_flag))
      else $error("overflow flag rose while halted");
   a_read_holds: assert property (
      !$past(counter_high_rd) && !$past(counter_low_rd) |-> $stable(counter_rd_data))
      else $error("counter read data moved without a read");

   // =====================
   // Channel events and pins
   a_flag_sticky: assert property (
      channel_event_flag[0] && !channel_flag_clear[0] |=> channel_event_flag[0])
      else $error("channel flag fell without a clear");
   a_irq_tracks_flag: assert property (
      channel_irq[0] == (channel_event_flag[0] && channel_status_control[0][`TMR_SC_IE]))
      else $error("channel request differs from flag and enable");
   a_capture_on_rise: assert property (
      cap0 && sel0 == `TMR_EDGE_RISE && $rose(channel_pin_in[0])
      && !channel_status_control_wr[0] |=> channel_event_flag[0])
      else $error("rising edge not captured");
   a_capture_no_edge: assert property (
      cap0 && sel0 == `TMR_EDGE_RISE && !$rose(channel_pin_in[0]) && !channel_event_flag[0]
      && !channel_status_control_wr[0] |=> !channel_event_flag[0])
      else $error("flag set without an active edge");
   a_capture_pin_free: assert property (
      cap0 [*2] |-> channel_pin_oe_n[0])
      else $error("capture pin driven");
   a_compare_pin_drive: assert property (
      (!center_aligned_select && mode0 == `TMR_MODE_COMPARE) [*2] |-> !channel_pin_oe_n[0])
      else $error("compare pin not driven");
   a_compare_halt_still: assert property (
      (debug_halt_mode && !center_aligned_select && mode0 == `TMR_MODE_COMPARE
      && !channel_status_control_wr[0]) [*2] |-> $stable(channel_pin_out[0]))
      else $error("compare pin moved while halted");
endmodule
